//--- design/acf_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ACF_DEFS_SVH
`define ACF_DEFS_SVH
`define ACF_ADDR_W 4
`define ACF_OFS_CTL1 4'h1
`define ACF_OFS_FLOW 4'h4
`define ACF_OFS_MODE 4'h5
`define ACF_OFS_CMD 4'h6
`define ACF_OFS_STAT 4'h7
`define ACF_B_LIST 7
`define ACF_B_RES 6
`define ACF_B_SACC 5
`define ACF_B_AUTO 4
`define ACF_B_ABORT 0
`define ACF_B_GO 1
`define ACF_B_RST 2
`define ACF_B_LOAD_OK 3
`define ACF_B_FMODE 0
`define ACF_B_ACC_LO 4
`define ACF_CTL1_RST 8'h00
`define ACF_CMD_RST 8'h00
`define ACF_ACC_BUS 2'h1
`define ACF_ACC_INT 2'h2
`define ACF_ABORT_CYC 4'h4
`define ACF_RESTART_CYC 4'h4
`define ACF_CONV_CYC 8'h20
`define ACF_LIST_LEN 3'h4
`endif

//--- design/acf_pkg.sv
// types for the conversion flow control block
package acf_pkg;
  typedef struct packed {
    logic abort;
    logic go;
    logic restart;
    logic load_ok;
  } acf_req_s;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RESTART = 5'h02,
    ST_ARMED = 5'h04,
    ST_CONV = 5'h08,
    ST_ABORT = 5'h10
  } acf_state_e;
endpackage : acf_pkg

//--- design/acf_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module acf_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule : acf_sync
`default_nettype wire

//--- design/acf_req_sel.sv
// merges bus and internal requests under the access select field
`timescale 1ns/10ps
`default_nettype none
module acf_req_sel (
  input wire logic [1:0] acc_sel,
  input wire acf_pkg::acf_req_s bus_req,
  input wire acf_pkg::acf_req_s int_req,
  output acf_pkg::acf_req_s req
);
  logic bus_en;
  logic int_en;
  always_comb begin
    bus_en = acc_sel[0];
    int_en = acc_sel[1];
    req.abort = (bus_en & bus_req.abort) | (int_en & int_req.abort);
    req.go = (bus_en & bus_req.go) | (int_en & int_req.go);
    req.restart = (bus_en & bus_req.restart) | (int_en & int_req.restart);
    req.load_ok = (bus_en & bus_req.load_ok) | (int_en & int_req.load_ok);
  end
endmodule : acf_req_sel
`default_nettype wire

//--- design/acf_flow_ctrl.sv
// converter flow control: control register, request sequencing, avalon slave
//
// Contract
// - list and result buffer mode bits take writes only while the converter is off or special access is set.
// - special access is writable only in special mode and clears itself when special mode ends.
// - with special access clear the per-bit write limits apply, with it set they are lifted.
// - with special access set the current command register is writable until its conversion starts.
// - auto restart is writable anytime and, when set, makes a restart on exit from stop or halted wait.
// - list buffer mode selects one command list (0) or two double-buffered lists (1).
// - result buffer mode selects one result list (0) or two double-buffered lists (1).
// - requests are taken from the bus, the internal interface or both as the access select says.
// - flow runs from abort, go, restart and load ok requests in trigger mode or restart mode.
// - a restart and a trigger, in turn or together by mode, start conversion from list a.
// - load ok with the restart then a trigger starts conversion from list b.
// - an abort request stops any sequence and clears only once the converter is idle.
// - restart request clears when the restart ends, then a trigger starts from the list top.
`include "acf_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module acf_flow_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic special_mode_pin,
  input wire logic stop_exit_pin,
  input wire logic wait_exit_pin,
  input wire logic wait_halt,
  input wire logic conv_on,
  input wire logic int_abort,
  input wire logic int_go,
  input wire logic int_restart,
  input wire logic int_load_ok,
  output logic list_buffer_mode,
  output logic result_buffer_mode,
  output logic converting,
  output logic active_list_b,
  output logic [2:0] cmd_index,
  output logic [7:0] current_command_reg
);
  logic special_access;
  logic auto_restart_after_stop;
  logic [1:0] flow_access_select;
  logic restart_mode;
  logic abort_request;
  logic restart_request;
  logic conversion_go_request;
  logic load_ok;
  logic special_mode;
  logic stop_exit;
  logic wait_exit;
  logic stop_exit_d;
  logic wait_exit_d;
  logic auto_ev;
  logic wr_acc;
  logic rd_acc;
  logic bus_busy;
  logic [7:0] ctl1_rst;
  logic cmd_started;
  logic [7:0] cnt;
  acf_pkg::acf_state_e state;
  acf_pkg::acf_req_s bus_req;
  acf_pkg::acf_req_s int_req;
  acf_pkg::acf_req_s req;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and request merge
  acf_sync u_sync_smod (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .din(special_mode_pin),
    .dout(special_mode)
  );
  acf_sync u_sync_stop (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .din(stop_exit_pin),
    .dout(stop_exit)
  );
  acf_sync u_sync_wait (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .din(wait_exit_pin),
    .dout(wait_exit)
  );

  always_comb begin
    bus_req.abort = wr_acc && avs_address == `ACF_OFS_FLOW && avs_writedata[`ACF_B_ABORT];
    bus_req.go = wr_acc && avs_address == `ACF_OFS_FLOW && avs_writedata[`ACF_B_GO];
    bus_req.restart = wr_acc && avs_address == `ACF_OFS_FLOW && avs_writedata[`ACF_B_RST];
    bus_req.load_ok = wr_acc && avs_address == `ACF_OFS_FLOW && avs_writedata[`ACF_B_LOAD_OK];
    int_req.abort = int_abort;
    int_req.go = int_go;
    int_req.restart = int_restart;
    int_req.load_ok = int_load_ok;
  end

  acf_req_sel u_req_sel (
    .acc_sel(flow_access_select),
    .bus_req(bus_req),
    .int_req(int_req),
    .req(req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on the second edge
  // waitrequest is its own flop, high while idle, low for the answer cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  always_comb begin
    bus_busy = !avs_waitrequest;
    wr_acc = avs_write && bus_busy && ce;
    rd_acc = avs_read && !bus_busy && ce;
    ctl1_rst = `ACF_CTL1_RST;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 8'h00;
    end else if (rd_acc) begin
      case (avs_address)
        `ACF_OFS_CTL1: avs_readdata <= {list_buffer_mode, result_buffer_mode,
                                        special_access, auto_restart_after_stop, 4'h0};
        `ACF_OFS_FLOW: avs_readdata <= {4'h0, load_ok, restart_request,
                                        conversion_go_request, abort_request};
        `ACF_OFS_MODE: avs_readdata <= {2'h0, flow_access_select, 3'h0, restart_mode};
        `ACF_OFS_CMD: avs_readdata <= current_command_reg;
        `ACF_OFS_STAT: avs_readdata <= {3'h0, state};
        default: avs_readdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register one
  always_ff @(posedge clk) begin
    if (srst) begin
      // reset values are picked from the register's reset word
      list_buffer_mode <= ctl1_rst[`ACF_B_LIST];
      result_buffer_mode <= ctl1_rst[`ACF_B_RES];
      auto_restart_after_stop <= ctl1_rst[`ACF_B_AUTO];
    end else if (ce && wr_acc && avs_address == `ACF_OFS_CTL1) begin
      auto_restart_after_stop <= avs_writedata[`ACF_B_AUTO];
      if (!conv_on || special_access) begin
        list_buffer_mode <= avs_writedata[`ACF_B_LIST];
        result_buffer_mode <= avs_writedata[`ACF_B_RES];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      special_access <= ctl1_rst[`ACF_B_SACC];
    end else if (ce) begin
      if (!special_mode) begin
        special_access <= 1'b0;
      end else if (wr_acc && avs_address == `ACF_OFS_CTL1) begin
        special_access <= avs_writedata[`ACF_B_SACC];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flow_access_select <= `ACF_ACC_BUS;
      restart_mode <= 1'b0;
    end else if (ce && wr_acc && avs_address == `ACF_OFS_MODE) begin
      flow_access_select <= avs_writedata[`ACF_B_ACC_LO +: 2];
      restart_mode <= avs_writedata[`ACF_B_FMODE];
    end
  end

  // current command: debug write while its conversion has not started
  always_ff @(posedge clk) begin
    if (srst) begin
      current_command_reg <= `ACF_CMD_RST;
    end else if (ce && wr_acc && avs_address == `ACF_OFS_CMD) begin
      if (special_access && !cmd_started) begin
        current_command_reg <= avs_writedata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // automatic restart on exit from stop or halted wait
  always_ff @(posedge clk) begin
    if (srst) begin
      stop_exit_d <= 1'b0;
      wait_exit_d <= 1'b0;
      auto_ev <= 1'b0;
    end else if (ce) begin
      stop_exit_d <= stop_exit;
      wait_exit_d <= wait_exit;
      auto_ev <= auto_restart_after_stop &&
                 ((stop_exit && !stop_exit_d) || (wait_exit && !wait_exit_d && wait_halt));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request bits: set by one, cleared by the device (load ok is only reloaded on each restart); set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      abort_request <= 1'b0;
    end else if (ce) begin
      if (req.abort) begin
        abort_request <= 1'b1;
      end else if (state == acf_pkg::ST_ABORT && cnt == 8'h00) begin
        abort_request <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      restart_request <= 1'b0;
      load_ok <= 1'b0;
    end else if (ce) begin
      if (req.restart || auto_ev) begin
        restart_request <= 1'b1;
        load_ok <= req.load_ok;
      end else if (state == acf_pkg::ST_RESTART && cnt == 8'h00) begin
        restart_request <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_go_request <= 1'b0;
    end else if (ce) begin
      if (req.go && !abort_request) begin
        conversion_go_request <= 1'b1;
      end else if (state == acf_pkg::ST_ARMED || state == acf_pkg::ST_CONV) begin
        conversion_go_request <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= acf_pkg::ST_IDLE;
      cnt <= 8'h00;
      cmd_index <= 3'h0;
      cmd_started <= 1'b0;
      active_list_b <= 1'b0;
      converting <= 1'b0;
    end else if (ce) begin
      case (state)
        acf_pkg::ST_IDLE: begin
          converting <= 1'b0;
          if (abort_request) begin
            state <= acf_pkg::ST_ABORT;
            cnt <= {4'h0, `ACF_ABORT_CYC};
          end else if (restart_request) begin
            state <= acf_pkg::ST_RESTART;
            cnt <= {4'h0, `ACF_RESTART_CYC};
          end
        end
        acf_pkg::ST_RESTART: begin
          if (abort_request) begin
            state <= acf_pkg::ST_ABORT;
            cnt <= {4'h0, `ACF_ABORT_CYC};
          end else if (cnt == 8'h00) begin
            cmd_index <= 3'h0;
            // list b only when double buffered and load ok came with the restart
            active_list_b <= list_buffer_mode && load_ok;
            state <= acf_pkg::ST_ARMED;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        acf_pkg::ST_ARMED: begin
          // restart mode runs straight on; trigger mode waits for go
          if (abort_request) begin
            state <= acf_pkg::ST_ABORT;
            cnt <= {4'h0, `ACF_ABORT_CYC};
          end else if (restart_mode || conversion_go_request) begin
            state <= acf_pkg::ST_CONV;
            cnt <= `ACF_CONV_CYC;
            cmd_started <= 1'b1;
            converting <= 1'b1;
          end
        end
        acf_pkg::ST_CONV: begin
          if (abort_request) begin
            state <= acf_pkg::ST_ABORT;
            cnt <= {4'h0, `ACF_ABORT_CYC};
            converting <= 1'b0;
            cmd_started <= 1'b0;
          end else if (cnt == 8'h00) begin
            cmd_started <= 1'b0;
            if (cmd_index == `ACF_LIST_LEN - 3'h1) begin
              converting <= 1'b0;
              state <= acf_pkg::ST_IDLE;
            end else begin
              cmd_index <= cmd_index + 3'h1;
              state <= acf_pkg::ST_ARMED;
            end
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        acf_pkg::ST_ABORT: begin
          converting <= 1'b0;
          if (cnt == 8'h00) begin
            state <= acf_pkg::ST_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          state <= acf_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule : acf_flow_ctrl
`default_nettype wire

//--- tb/acf_flow_chk_sva.sv
// checker for the conversion flow control block
`timescale 1ns/10ps
`default_nettype none
module acf_flow_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic list_buffer_mode,
  input wire logic result_buffer_mode,
  input wire logic converting,
  input wire logic active_list_b,
  input wire logic [2:0] cmd_index
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic ctl_wr;
  assign ctl_wr = avs_write && !avs_waitrequest && avs_address == 4'h1;
  a_list_mode_write: assert property ($changed(list_buffer_mode) |-> $past(ctl_wr))
    else $error("list mode moved without write");
  a_res_mode_write: assert property ($changed(result_buffer_mode) |-> $past(ctl_wr))
    else $error("result mode moved without write");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  a_index_range: assert property (converting |-> cmd_index < 3'h4)
    else $error("command index past list end");
  a_index_step: assert property ($changed(cmd_index) |->
    cmd_index == $past(cmd_index) + 3'h1 || cmd_index == 3'h0)
    else $error("command index skipped");
  a_list_b_mode: assert property ($rose(active_list_b) |-> list_buffer_mode)
    else $error("list b without double buffer");
  a_list_b_hold: assert property (converting && $past(converting) |-> $stable(active_list_b))
    else $error("list changed mid sequence");
  c_conv: cover property ($rose(converting));
  c_list_b: cover property ($rose(active_list_b));
  c_done: cover property ($fell(converting));
endmodule : acf_flow_chk
bind acf_flow_ctrl acf_flow_chk u_chk (.clk, .srst, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .list_buffer_mode, .result_buffer_mode, .converting,
  .active_list_b, .cmd_index);
`default_nettype wire

//--- tb/acf_int_src.sv
// model of the internal request source
`timescale 1ns/10ps
`default_nettype none
module acf_int_src (
  input wire logic clk,
  input wire acf_pkg::acf_req_s cmd,
  input wire logic busy,
  output var acf_pkg::acf_req_s req
);
  // one-cycle pulses, restart held back while converting
  always_ff @(posedge clk) begin
    req.abort <= cmd.abort;
    req.go <= cmd.go;
    req.restart <= cmd.restart && !busy;
    req.load_ok <= cmd.load_ok;
  end
endmodule : acf_int_src
`default_nettype wire

//--- tb/tb_acf_flow_ctrl.sv
// testbench for the conversion flow control block
`timescale 1ns/10ps
`default_nettype none
module tb_acf_flow_ctrl;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata, ccmd, q;
  logic avs_waitrequest, lbm, rbm, conv, list_b;
  logic smode = 1'b0, stop_x = 1'b0, wait_x = 1'b0, halt = 1'b0, conv_on = 1'b0;
  acf_pkg::acf_req_s pcmd = '0;
  acf_pkg::acf_req_s ireq;
  logic [2:0] idx;
  int fails = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;
  acf_flow_ctrl dut (.clk, .srst, .ce(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .special_mode_pin(smode), .stop_exit_pin(stop_x),
    .wait_exit_pin(wait_x), .wait_halt(halt), .conv_on, .int_abort(ireq.abort), .int_go(ireq.go),
    .int_restart(ireq.restart), .int_load_ok(ireq.load_ok), .list_buffer_mode(lbm),
    .result_buffer_mode(rbm), .converting(conv), .active_list_b(list_b), .cmd_index(idx),
    .current_command_reg(ccmd));
  acf_int_src u_src (.clk, .cmd(pcmd), .busy(conv), .req(ireq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task automatic bad(input string m);
    fails++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : bad
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    while (!ok && n < 40) begin
      @(posedge clk);
      ok = (avs_waitrequest === 1'b0);
      q = avs_readdata;
      n++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (!ok) begin
      bad("no bus answer");
      test_done();
    end
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic ckv(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      bad($sformatf("got %h want %h", g, e));
    end
  endtask : ckv
  task automatic ck(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    ckv(q, e);
  endtask : ck
  task automatic wt(input logic [3:0] a, input logic [7:0] m);
    int n;
    n = 0;
    q = m;
    while ((q & m) !== 8'h00 && n < 80) begin
      bus(1'b0, a, 8'h00);
      n++;
    end
    if ((q & m) !== 8'h00) begin
      bad("wait ran out");
      test_done();
    end
  endtask : wt
  task automatic send(input acf_pkg::acf_req_s r);
    @(posedge clk);
    pcmd <= r;
    @(posedge clk);
    pcmd <= '0;
  endtask : send
  task automatic exit_pulse(input logic w);
    stop_x <= !w;
    wait_x <= w;
    repeat (8) @(posedge clk);
    stop_x <= 1'b0;
    wait_x <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : exit_pulse
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    ck(4'h1, 8'h00);
    ck(4'h5, 8'h10);
    ck(4'h7, 8'h01);
    ck(4'h2, 8'h00);
    conv_on <= 1'b1;
    wr(4'h1, 8'hf0);
    ck(4'h1, 8'h10);
    conv_on <= 1'b0;
    wr(4'h1, 8'hc0);
    ck(4'h1, 8'hc0);
    ckv({7'h00, lbm}, 8'h01);
    ckv({7'h00, rbm}, 8'h01);
    $display("test mode bits done");
    smode <= 1'b1;
    conv_on <= 1'b1;
    repeat (8) @(posedge clk);
    wr(4'h1, 8'h20);
    wr(4'h1, 8'h60);
    ck(4'h1, 8'h60);
    wr(4'h6, 8'h5a);
    ck(4'h6, 8'h5a);
    ckv(ccmd, 8'h5a);
    smode <= 1'b0;
    repeat (8) @(posedge clk);
    ck(4'h1, 8'h40);
    wr(4'h6, 8'h11);
    ck(4'h6, 8'h5a);
    conv_on <= 1'b0;
    wr(4'h1, 8'hc0);
    $display("test special access done");
    wr(4'h4, 8'h04);
    wt(4'h4, 8'h04);
    ck(4'h7, 8'h04);
    wr(4'h4, 8'h02);
    ck(4'h7, 8'h08);
    ckv({7'h00, list_b}, 8'h00);
    ckv({7'h00, conv}, 8'h01);
    ckv({5'h00, idx}, 8'h00);
    wr(4'h4, 8'h01);
    wt(4'h4, 8'h01);
    ck(4'h7, 8'h01);
    wr(4'h4, 8'h0c);
    wt(4'h4, 8'h04);
    wr(4'h4, 8'h02);
    ck(4'h7, 8'h08);
    ckv({7'h00, list_b}, 8'h01);
    wr(4'h4, 8'h01);
    wt(4'h4, 8'h01);
    $display("test trigger mode done");
    wr(4'h5, 8'h20);
    wr(4'h4, 8'h04);
    repeat (10) @(posedge clk);
    ck(4'h7, 8'h01);
    send(4'b0010);
    repeat (8) @(posedge clk);
    ck(4'h7, 8'h04);
    send(4'b0100);
    repeat (4) @(posedge clk);
    ck(4'h7, 8'h08);
    send(4'b1000);
    repeat (8) @(posedge clk);
    ck(4'h7, 8'h01);
    wr(4'h5, 8'h31);
    wr(4'h4, 8'h04);
    wt(4'h4, 8'h04);
    ck(4'h7, 8'h08);
    wt(4'h7, 8'h0c);
    ck(4'h7, 8'h01);
    ckv({5'h00, idx}, 8'h03);
    ckv({7'h00, conv}, 8'h00);
    $display("test access and restart mode done");
    exit_pulse(1'b0);
    ck(4'h7, 8'h01);
    wr(4'h1, 8'hd0);
    halt <= 1'b1;
    exit_pulse(1'b1);
    ck(4'h7, 8'h08);
    ckv({7'h00, conv}, 8'h01);
    $display("test auto restart done");
    test_done();
  end
  initial begin
    #100000;
    bad("run timed out");
    test_done();
  end
endmodule : tb_acf_flow_ctrl
`default_nettype wire
